// File: rtl/hisa_top.sv
/*
 Host interrupt status and acknowledge word of the host control block, with the
 interrupt control byte of the command word (masks and software request).
 Assumes a PCI slave front end that presents byte-lane reads and writes to the
 first control dword as single-cycle strobes, and unit state machines that give
 one-cycle event pulses in the same clock domain.
*/
`default_nettype none
// Behaviour
// [RULE1] Status word read/written as two bytes
// [RULE2] Interrupt asserted while any cause pending
// [RULE3] Writing 1 clears that cause bit
// [RULE4] Interrupt stays until all causes acknowledged
// [RULE5] Host may acknowledge over several writes
// [RULE6] Causes latched; interrupt is a level
// [RULE7] Ack of idle cause or 0 ignored
// [RULE8] Bit 15 command done or failed transmit
// [RULE9] Bit 14 frame or header received
// [RULE10] Bit 13 leave-active or enter-idle mode
// [RULE11] Bit 12 receive unit leaves ready
// [RULE12] Bit 11 management cycle done if enabled
// [RULE13] Bit 10 software requested interrupt
// [RULE14] Bit 8 pause frame received
// [RULE15] Software avoids reserved bits 9, 1:0
// [RULE16] Bits 7:6 command unit state
// [RULE17] Bits 5:2 receive unit state, legal only
// [RULE18] State fields may lag commands
// [RULE19] Software tracks issued commands itself
// [RULE20] Causes clear only by acknowledge
// [RULE21] Global mask keeps pin deasserted
// [RULE22] Per-cause masks block their causes
// [RULE23] Software request bit write-one, reads zero
// [RULE24] Host writes to state byte ignored
module hisa_top
	import hisa_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [1:0] reg_byte_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic cmd_done_irq_in,
	input wire logic tx_failed_in,
	input wire logic cmd_done_on_fail_mode_in,
	input wire logic frame_done_in,
	input wire logic header_done_in,
	input wire logic header_mode_in,
	input wire logic cu_left_active_in,
	input wire logic cu_enter_idle_in,
	input wire logic cmd_unit_enter_idle_mode_in,
	input wire logic rx_left_ready_in,
	input wire logic mgmt_cycle_done_in,
	input wire logic [31:0] mgmt_ctrl_in,
	input wire logic pause_frame_in,
	input wire logic [1:0] cu_state_in,
	input wire logic [3:0] rx_unit_state_in,
	output logic [7:0] irq_ctrl_out,
	output logic irq_out
);
	typedef struct packed {
		logic [7:0] irq_ctrl;
		logic [7:0] rdata;
		logic irq;
	} hisa_top_state_t;
	hisa_top_state_t state;
	hisa_top_state_t next_state;

	logic [7:0] cause_event;
	logic [7:0] cause_ack;
	logic [7:0] pending;
	logic [7:0] cause_mask;
	logic [1:0] cu_state_shown;
	logic [3:0] ru_state_shown;
	logic ack_wr;
	logic ctrl_wr;
	logic sw_req_wr;

	// Ack byte and interrupt control byte are independent lanes; see [RULE1]
	assign ack_wr = reg_wr_in && (reg_byte_in == HISA_OFF_ACK_BYTE);
	assign ctrl_wr = reg_wr_in && (reg_byte_in == HISA_OFF_IRQ_CTRL);
	// A simultaneous global mask write swallows the request; see [RULE23]
	assign sw_req_wr = ctrl_wr && reg_wdata_in[HISA_CTL_SW_REQ] && !reg_wdata_in[HISA_CTL_GLOBAL_MASK];

	always_comb begin
		cause_event = '0;
		// see [RULE8]
		cause_event[HISA_BIT_CMD_DONE] = cmd_done_on_fail_mode_in ? tx_failed_in : cmd_done_irq_in;
		// see [RULE9]
		cause_event[HISA_BIT_FRAME_RX] = header_mode_in ? header_done_in : frame_done_in;
		// see [RULE10]
		cause_event[HISA_BIT_CU_LEFT] = cmd_unit_enter_idle_mode_in ? cu_enter_idle_in : cu_left_active_in;
		cause_event[HISA_BIT_RX_NOT_READY] = rx_left_ready_in; // see [RULE11]
		// see [RULE12]
		cause_event[HISA_BIT_MGMT] = mgmt_cycle_done_in && mgmt_ctrl_in[HISA_MGMT_IRQ_EN_BIT];
		cause_event[HISA_BIT_SW_REQ] = sw_req_wr; // see [RULE13]
		cause_event[HISA_BIT_PAUSE] = pause_frame_in; // see [RULE14]
	end

	// Only ones in the ack byte clear, and only on valid cause bits; see [RULE7]
	assign cause_ack = ack_wr ? (reg_wdata_in & HISA_CAUSE_VALID) : 8'h00;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_cause
			if (HISA_CAUSE_VALID[gi]) begin : g_live
				hisa_cause_bit u_cause (
					.clk_in(clk_in),
					.rst_n_in(rst_n_in),
					.event_in(cause_event[gi]),
					.ack_in(cause_ack[gi]),
					.pending_out(pending[gi])
				); // see [RULE6]
			end else begin : g_rsvd
				assign pending[gi] = 1'b0;
			end
		end
	endgenerate

	// State fields come only from the unit machines, never from host writes; see [RULE24]
	// The extra register stage means a field may lag its unit by a cycle; see [RULE18]
	hisa_unit_state #(
		.WIDTH(2),
		.LEGAL(16'h000f)
	) u_cu_state (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.state_in(cu_state_in),
		.state_out(cu_state_shown)
	); // see [RULE16]

	hisa_unit_state #(
		.WIDTH(4),
		.LEGAL(16'h0017)
	) u_ru_state (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.state_in(rx_unit_state_in),
		.state_out(ru_state_shown)
	); // see [RULE17]

	// Per-cause masks map onto status bits; management and software causes have no mask
	always_comb begin
		cause_mask = '0;
		cause_mask[HISA_BIT_CMD_DONE] = state.irq_ctrl[HISA_CTL_MASK_CMD_DONE];
		cause_mask[HISA_BIT_FRAME_RX] = state.irq_ctrl[HISA_CTL_MASK_FRAME_RX];
		cause_mask[HISA_BIT_CU_LEFT] = state.irq_ctrl[HISA_CTL_MASK_CU_LEFT];
		cause_mask[HISA_BIT_RX_NOT_READY] = state.irq_ctrl[HISA_CTL_MASK_RX_NOT_READY];
		cause_mask[HISA_BIT_PAUSE] = state.irq_ctrl[HISA_CTL_MASK_PAUSE];
	end

	always_comb begin
		next_state = state;
		if (ctrl_wr) begin
			// Request bit is an action, not stored
			next_state.irq_ctrl = reg_wdata_in;
			next_state.irq_ctrl[HISA_CTL_SW_REQ] = 1'b0; // see [RULE23]
		end
		// Level from latched causes; drops only when none unmasked remain or the global mask is set; see [RULE2] [RULE4] [RULE22]
		next_state.irq = |(pending & ~cause_mask);
		// Global mask overrides everything; see [RULE21]
		if (state.irq_ctrl[HISA_CTL_GLOBAL_MASK]) begin
			next_state.irq = 1'b0;
		end
		if (reg_rd_in) begin
			case (reg_byte_in)
				HISA_OFF_STATE_BYTE: begin
					next_state.rdata = {cu_state_shown, ru_state_shown, 2'h0};
				end
				HISA_OFF_ACK_BYTE: begin
					next_state.rdata = pending;
				end
				HISA_OFF_IRQ_CTRL: begin
					next_state.rdata = state.irq_ctrl;
				end
				default: begin
					next_state.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state.irq_ctrl <= HISA_RST_IRQ_CTRL;
			state.rdata <= 8'h00;
			state.irq <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata_out = state.rdata;
	assign irq_ctrl_out = state.irq_ctrl;
	assign irq_out = state.irq;
endmodule
`default_nettype wire

// File: rtl/hisa_pkg.sv
/*
 Package for the host interrupt status/acknowledge block: offsets, bit positions,
 unit state encodings and reset values.
 Assumes a single clock domain and byte-lane register access.
*/
`default_nettype none
package hisa_pkg;
	// Byte offsets within the first control dword (status word low half, command word high half)
	localparam logic [1:0] HISA_OFF_STATE_BYTE = 2'h0;
	localparam logic [1:0] HISA_OFF_ACK_BYTE = 2'h1;
	localparam logic [1:0] HISA_OFF_CMD_LOW = 2'h2;
	localparam logic [1:0] HISA_OFF_IRQ_CTRL = 2'h3;
	// Cause positions within the ack byte (status word bits 15:8)
	localparam int HISA_BIT_CMD_DONE = 7;
	localparam int HISA_BIT_FRAME_RX = 6;
	localparam int HISA_BIT_CU_LEFT = 5;
	localparam int HISA_BIT_RX_NOT_READY = 4;
	localparam int HISA_BIT_MGMT = 3;
	localparam int HISA_BIT_SW_REQ = 2;
	localparam int HISA_BIT_RSVD9 = 1;
	localparam int HISA_BIT_PAUSE = 0;
	// Positions within interrupt control byte (command word bits 31:24)
	localparam int HISA_CTL_MASK_CMD_DONE = 7;
	localparam int HISA_CTL_MASK_FRAME_RX = 6;
	localparam int HISA_CTL_MASK_CU_LEFT = 5;
	localparam int HISA_CTL_MASK_RX_NOT_READY = 4;
	localparam int HISA_CTL_MASK_EARLY_RX = 3;
	localparam int HISA_CTL_MASK_PAUSE = 2;
	localparam int HISA_CTL_SW_REQ = 1;
	localparam int HISA_CTL_GLOBAL_MASK = 0;
	// Lower status byte field positions
	localparam int HISA_CU_STATE_LSB = 6;
	localparam int HISA_RU_STATE_LSB = 2;
	// Management control register interrupt enable position
	localparam int HISA_MGMT_IRQ_EN_BIT = 29;
	// Unit state encodings
	localparam logic [1:0] HISA_CU_IDLE = 2'h0;
	localparam logic [1:0] HISA_CU_SUSPENDED = 2'h1;
	localparam logic [1:0] HISA_CU_ACTIVE_LOW = 2'h2;
	localparam logic [1:0] HISA_CU_ACTIVE_HIGH = 2'h3;
	localparam logic [3:0] HISA_RU_IDLE = 4'h0;
	localparam logic [3:0] HISA_RU_SUSPENDED = 4'h1;
	localparam logic [3:0] HISA_RU_NO_RESOURCES = 4'h2;
	localparam logic [3:0] HISA_RU_READY = 4'h4;
	// Reset values
	localparam logic [7:0] HISA_RST_CAUSES = 8'h00;
	localparam logic [7:0] HISA_RST_IRQ_CTRL = 8'h00;
	// Valid cause bits (bit 9 of the word reserved)
	localparam logic [7:0] HISA_CAUSE_VALID = 8'hfd;
endpackage
`default_nettype wire

// File: rtl/hisa_cause_bit.sv
/*
 One sticky interrupt cause flag: set by a hardware event, cleared by a host
 write of 1. Assumes the event and ack are single-cycle qualified strobes.
*/
`default_nettype none
module hisa_cause_bit (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic event_in,
	input wire logic ack_in,
	output logic pending_out
);
	typedef struct packed {
		logic pending;
	} hisa_cb_state_t;
	hisa_cb_state_t state;
	hisa_cb_state_t next_state;

	always_comb begin
		next_state = state;
		// Event wins over a same-cycle ack so no cause is lost; see [RULE20]
		if (event_in) begin
			next_state.pending = 1'b1;
		end else if (ack_in) begin
			next_state.pending = 1'b0; // see [RULE3]
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pending_out = state.pending;
endmodule
`default_nettype wire

// File: rtl/hisa_unit_state.sv
/*
 Registers one unit state field for the lower status byte, filtering out
 encodings that must never be shown. Assumes state_in comes from the unit's
 own state machine in the same clock domain.
*/
`default_nettype none
module hisa_unit_state #(
	parameter int WIDTH = 2,
	parameter logic [15:0] LEGAL = 16'h000f
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] state_in,
	output logic [WIDTH-1:0] state_out
);
	typedef struct packed {
		logic [WIDTH-1:0] field;
	} hisa_us_state_t;
	hisa_us_state_t state;
	hisa_us_state_t next_state;

	always_comb begin
		next_state = state;
		// Illegal codes hold the last shown value; a glitching unit never leaks one
		if (LEGAL[state_in]) begin
			next_state.field = state_in; // see [RULE17]
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign state_out = state.field;
endmodule
`default_nettype wire

// File: verif/hisa_host_model.sv
/* Host software model: byte-lane reads and writes of the first control dword.
 Assumes strobes are sampled on the rising edge and read data follows one cycle later. */
`default_nettype none
module hisa_host_model (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic [1:0] byte_out,
	output logic wr_out,
	output logic [7:0] wdata_out,
	output logic rd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		byte_out = 2'h0;
		wr_out = 1'b0;
		wdata_out = 8'h00;
		rd_out = 1'b0;
	end
	// Callers may ack over several writes; t_state writes 8'hff to the state byte, reserved bits 1:0 included
	task automatic wr(input logic [1:0] b, input logic [7:0] d);
		@(negedge clk_in);
		byte_out = b;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		wdata_out = ~d;
	endtask
	// State is only read back, never used to sequence commands
	task automatic rd(input logic [1:0] b, output logic [7:0] d);
		@(negedge clk_in);
		byte_out = b;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

// File: verif/hisa_props.sv
/* Port assertions for the interrupt status/ack block.
 Assumes the one-cycle strobe and fixed latency contract of the block. */
`default_nettype none
module hisa_props (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [1:0] reg_byte_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic pause_frame_in,
	input wire logic [1:0] cu_state_in,
	input wire logic [7:0] irq_ctrl_out,
	input wire logic irq_out
);
	import hisa_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_pause_irq: assert property (pause_frame_in && irq_ctrl_out[2:0] == 3'h0 && !reg_wr_in
		##1 !reg_wr_in |=> irq_out) else $error("pause event raised no interrupt");
	a_global_mask: assert property (irq_ctrl_out[0] ##1 irq_ctrl_out[0] |-> !irq_out)
		else $error("interrupt while globally masked");
	a_sw_zero: assert property (!irq_ctrl_out[HISA_CTL_SW_REQ]) else $error("software bit read back set");
	a_irq_holds: assert property (!reg_wr_in ##1 !reg_wr_in && irq_out |=> irq_out)
		else $error("interrupt dropped without a write");
	a_state_read: assert property ($stable(cu_state_in) ##1 reg_rd_in && reg_byte_in == 2'h0
		|=> reg_rdata_out[7:6] == $past(cu_state_in, 2) && reg_rdata_out[1:0] == 2'h0) else $error("bad state byte");
	a_rx_legal: assert property (reg_rd_in && reg_byte_in == 2'h0
		|=> reg_rdata_out[5:2] inside {4'h0, 4'h1, 4'h2, 4'h4}) else $error("reserved receive state shown");
	a_ctrl_write: assert property (reg_wr_in && reg_byte_in == 2'h3
		|=> irq_ctrl_out == ($past(reg_wdata_in) & 8'hfd)) else $error("control byte not stored");
	a_cmd_low_zero: assert property (reg_rd_in && reg_byte_in == 2'h2 |=> reg_rdata_out == 8'h00)
		else $error("command low byte read nonzero");
endmodule
bind hisa_top hisa_props hisa_props_i (.*);
`default_nettype wire

// File: verif/tb_hisa_top.sv
/* Self-checking bench for the interrupt status/ack block.
 Assumes the host model drives the register strobes; events come from here. */
`default_nettype none
module tb_hisa_top;
	import hisa_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [1:0] reg_byte_in;
	logic reg_wr_in;
	logic reg_rd_in;
	logic [7:0] reg_wdata_in;
	logic [7:0] reg_rdata_out;
	logic [7:0] irq_ctrl_out;
	logic [7:0] rd_v;
	logic irq_out;
	logic [8:0] ev = 9'h000;
	logic [3:0] md = 4'h0;
	logic [1:0] cu_st = 2'h0;
	logic [3:0] rx_st = 4'h0;
	int n_fail = 0;
	int check_count = 0;
	always #2 clk_in = ~clk_in;
	hisa_host_model hisa_host_model_i (.clk_in(clk_in), .rdata_in(reg_rdata_out), .byte_out(reg_byte_in),
		.wr_out(reg_wr_in), .wdata_out(reg_wdata_in), .rd_out(reg_rd_in));
	hisa_top hisa_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_byte_in(reg_byte_in), .reg_wr_in(reg_wr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.cmd_done_irq_in(ev[0]), .tx_failed_in(ev[1]), .cmd_done_on_fail_mode_in(md[0]), .frame_done_in(ev[2]),
		.header_done_in(ev[3]), .header_mode_in(md[1]), .cu_left_active_in(ev[4]), .cu_enter_idle_in(ev[5]),
		.cmd_unit_enter_idle_mode_in(md[2]), .rx_left_ready_in(ev[6]), .mgmt_cycle_done_in(ev[7]),
		.mgmt_ctrl_in({2'h0, md[3], 29'h0}), .pause_frame_in(ev[8]), .cu_state_in(cu_st),
		.rx_unit_state_in(rx_st), .irq_ctrl_out(irq_ctrl_out), .irq_out(irq_out));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (n_fail == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// One-cycle event as the units give it, then one more edge for the level to follow
	task automatic pulse(input logic [8:0] e);
		@(negedge clk_in);
		ev = e;
		@(negedge clk_in);
		ev = 9'h000;
		@(negedge clk_in);
	endtask
	task automatic put(input logic [1:0] b, input logic [7:0] d);
		hisa_host_model_i.wr(b, d);
		@(negedge clk_in);
	endtask
	task automatic get(input logic [1:0] b);
		hisa_host_model_i.rd(b, rd_v);
	endtask
	task automatic t_causes();
		logic [15:0] tbl [14] = '{16'h0080, 16'h0100, 16'h1180, 16'h1000, 16'h2040, 16'h3240, 16'h2200,
			16'h4020, 16'h5420, 16'h5000, 16'h6010, 16'h7808, 16'h7000, 16'h8001};
		for (int i = 0; i < 14; i++) begin
			md = tbl[i][11:8];
			pulse(9'h001 << tbl[i][15:12]);
			check({7'h0, irq_out}, {7'h0, |tbl[i][7:0]});
			get(HISA_OFF_ACK_BYTE);
			check(rd_v, tbl[i][7:0]);
			put(HISA_OFF_ACK_BYTE, ~tbl[i][7:0] & HISA_CAUSE_VALID);
			get(HISA_OFF_ACK_BYTE);
			check(rd_v, tbl[i][7:0]);
			put(HISA_OFF_ACK_BYTE, tbl[i][7:0]);
			check({7'h0, irq_out}, 8'h00);
		end
		md = 4'h0;
	endtask
	task automatic t_multi();
		pulse(9'h101);
		put(HISA_OFF_ACK_BYTE, 8'h80);
		check({7'h0, irq_out}, 8'h01);
		pulse(9'h100);
		get(HISA_OFF_ACK_BYTE);
		check(rd_v, 8'h01);
		put(HISA_OFF_ACK_BYTE, 8'h01);
		check({7'h0, irq_out}, 8'h00);
	endtask
	task automatic t_masks();
		put(HISA_OFF_IRQ_CTRL, 8'h80);
		check(irq_ctrl_out, 8'h80);
		pulse(9'h001);
		check({7'h0, irq_out}, 8'h00);
		pulse(9'h100);
		check({7'h0, irq_out}, 8'h01);
		put(HISA_OFF_ACK_BYTE, 8'h01);
		put(HISA_OFF_IRQ_CTRL, 8'h00);
		check({7'h0, irq_out}, 8'h01);
		put(HISA_OFF_ACK_BYTE, 8'h80);
		put(HISA_OFF_IRQ_CTRL, 8'h03);
		get(HISA_OFF_ACK_BYTE);
		check(rd_v, 8'h00);
		put(HISA_OFF_IRQ_CTRL, 8'h01);
		pulse(9'h100);
		check({7'h0, irq_out}, 8'h00);
		put(HISA_OFF_IRQ_CTRL, 8'h02);
		check({7'h0, irq_out}, 8'h01);
		check(irq_ctrl_out, 8'h00);
		get(HISA_OFF_IRQ_CTRL);
		check(rd_v, 8'h00);
		get(HISA_OFF_ACK_BYTE);
		check(rd_v, 8'h05);
		put(HISA_OFF_ACK_BYTE, 8'h05);
		check({7'h0, irq_out}, 8'h00);
		// Every other per-cause mask, early receive bit stored as well
		put(HISA_OFF_IRQ_CTRL, 8'h7c);
		check(irq_ctrl_out, 8'h7c);
		pulse(9'h154);
		check({7'h0, irq_out}, 8'h00);
		get(HISA_OFF_ACK_BYTE);
		check(rd_v, 8'h71);
		put(HISA_OFF_IRQ_CTRL, 8'h00);
		check({7'h0, irq_out}, 8'h01);
		put(HISA_OFF_ACK_BYTE, 8'h71);
		check({7'h0, irq_out}, 8'h00);
	endtask
	task automatic t_state();
		logic [3:0] rx [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h9};
		logic [3:0] shown [5] = '{4'h1, 4'h2, 4'h2, 4'h4, 4'h4};
		for (int i = 0; i < 5; i++) begin
			cu_st = i[1:0];
			rx_st = rx[i];
			put(HISA_OFF_STATE_BYTE, 8'hff);
			get(HISA_OFF_STATE_BYTE);
			check(rd_v, {i[1:0], shown[i], 2'h0});
		end
		get(HISA_OFF_CMD_LOW);
		check(rd_v, 8'h00);
	endtask
	// Mid-run reset drops pending causes, masks, read data and the level
	task automatic t_reset();
		put(HISA_OFF_IRQ_CTRL, 8'h80);
		pulse(9'h101);
		check({7'h0, irq_out}, 8'h01);
		get(HISA_OFF_ACK_BYTE);
		check(rd_v, 8'h81);
		rst_n_in = 1'b0;
		repeat (2) @(negedge clk_in);
		check({7'h0, irq_out}, 8'h00);
		check(irq_ctrl_out, HISA_RST_IRQ_CTRL);
		check(reg_rdata_out, 8'h00);
		rst_n_in = 1'b1;
		get(HISA_OFF_ACK_BYTE);
		check(rd_v, HISA_RST_CAUSES);
		check({7'h0, irq_out}, 8'h00);
	endtask
	initial begin
		#100000;
		n_fail++;
		final_report();
	end
	initial begin
		repeat (4) @(negedge clk_in);
		rst_n_in = 1'b1;
		check({7'h0, irq_out}, 8'h00);
		t_causes();
		t_multi();
		t_masks();
		t_state();
		t_reset();
		final_report();
	end
endmodule
`default_nettype wire
